/* inc/spc_regs.vh */
`ifndef SPC_REGS_VH
`define SPC_REGS_VH
// ****************************************
// Timing
// ****************************************
`define SPC_CLK_MHZ          100
`define SPC_SAMPLE_TIME_US   1000
`define SPC_SAMPLE_CYCLES    (`SPC_SAMPLE_TIME_US * `SPC_CLK_MHZ)
// ****************************************
// Register byte offsets
// ****************************************
`define SPC_OFS_CTRL     8'h00
`define SPC_OFS_GAIN     8'h04
`define SPC_OFS_BRAKE    8'h08
`define SPC_OFS_WINDOW   8'h0C
`define SPC_OFS_VMAN     8'h10
`define SPC_OFS_VMAX     8'h14
`define SPC_OFS_ESTOP    8'h18
`define SPC_OFS_TRIG     8'h1C
`define SPC_OFS_SLOPE    8'h20
`define SPC_OFS_MINOUT   8'h24
`define SPC_OFS_EMERGENCY_OUTPUT_VALUE     8'h28
`define SPC_OFS_ISOL     8'h2C
`define SPC_OFS_STATUS   8'h30
`define SPC_OFS_POS      8'h34
`define SPC_OFS_OUT      8'h38
// ****************************************
// Control register fields
// ****************************************
`define SPC_CTRL_CUR_IN    0
`define SPC_CTRL_EXT_SPD   1
`define SPC_CTRL_CURVE_LO  2
`define SPC_CTRL_EMERGENCY_OUTPUT_VALUE_EN   4
`define SPC_CTRL_LAG_LO    5
`define SPC_CTRL_PSTAGE    8
`define SPC_CURVE_LIN      2'h0
`define SPC_CURVE_ROOT3    2'h1
`define SPC_CURVE_ROOT5    2'h2
// ****************************************
// Reset values and scaling
// ****************************************
`define SPC_RST_CTRL     9'h044
`define SPC_RST_GAIN     16'h0100
`define SPC_RST_BRAKE    4'hA
`define SPC_RST_WINDOW   16'h0040
`define SPC_RST_VMAN     15'h1000
`define SPC_RST_VMAX     15'h7FFF
`define SPC_RST_ESTOP    16'h0400
`define SPC_RST_TRIG     15'h0100
`define SPC_RST_SLOPE    32'h0100_0100
`define SPC_RST_MINOUT   15'h0000
`define SPC_RST_EMERGENCY_OUTPUT_VALUE     16'h0000
`define SPC_RST_IMIN     12'h1F4
`define SPC_RST_IMAX     12'hA28
`define SPC_CODE_4MA     16'h3333
`define SPC_CODE_BREAK   16'h2666
`define SPC_SPAN_16MA    16'hCCCC
`endif

/* hdl/spc_top.v */
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "spc_regs.vh"

module spc_top #(
  parameter SAMPLE_CYCLES = `SPC_SAMPLE_CYCLES
) (
  input  wire        ref_clk,        // System clock, 100 MHz
  input  wire        rst,            // Synchronous reset, active high
  input  wire        hsel,           // AHB slave select
  input  wire [31:0] haddr,          // AHB address
  input  wire [1:0]  htrans,         // AHB transfer type
  input  wire        hwrite,         // AHB write
  input  wire [2:0]  hsize,          // AHB size, word only
  input  wire [31:0] hwdata,         // AHB write data
  input  wire        hready,         // AHB bus ready
  output wire        hreadyout,      // Slave ready, always high
  output wire        hresp,          // Slave response, always OKAY
  output reg  [31:0] hrdata,         // AHB read data
  input  wire        enable_pin,     // Enable input pin
  input  wire        start_pin,      // Start input pin
  input  wire        jog_up_pin,     // Manual jog forward pin
  input  wire        jog_down_pin,   // Manual jog backward pin
  input  wire        sol_a_fault_pin,// Solenoid A fault pin
  input  wire        sol_b_fault_pin,// Solenoid B fault pin
  input  wire [15:0] cmd_pos_code,   // ADC code, command position
  input  wire [15:0] feedback_code,  // ADC code, actual position
  input  wire [15:0] cmd_speed_code, // ADC code, command speed
  output reg         ready,          // Ready output
  output reg         in_position,    // In-position status output
  output reg         valve_out_en,   // Valve output stage active
  output reg  [15:0] valve_dac_code, // 4-20 mA output DAC code
  output reg  [15:0] monitor_code,   // Monitor output DAC code
  output reg  [11:0] sol_a_ma,       // Solenoid A current set point, mA
  output reg  [11:0] sol_b_ma        // Solenoid B current set point, mA
);

  // ****************************************
  // Register file and AHB-Lite slave
  // ****************************************
  reg  [8:0]  ctrl_q;
  reg  [15:0] gain_q;
  reg  [3:0]  brake_q;
  reg  [15:0] window_q;
  reg  [14:0] vman_q;
  reg  [14:0] vmax_q;
  reg  [15:0] estop_q;
  reg  [14:0] trig_q;
  reg  [31:0] slope_q;
  reg  [14:0] minout_q;
  reg  [15:0] emergency_output_value_q;
  reg  [11:0] imin_q;
  reg  [11:0] imax_q;
  reg         wr_q;
  reg  [7:0]  waddr_q;
  reg  [31:0] rd_mux;
  reg  [15:0] target_q;
  reg  [15:0] out_q;
  reg  [3:0]  err_q;
  reg  [5:0]  pin_s;

  wire       acc      = hsel & htrans[1] & hready;
  wire [7:0] raddr    = {haddr[7:2], 2'b00};
  wire [15:0] actual;
  wire [15:0] cmd_pos;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always @* begin
    case (raddr)
      `SPC_OFS_CTRL:   rd_mux = {23'h00_0000, ctrl_q};
      `SPC_OFS_GAIN:   rd_mux = {16'h0000, gain_q};
      `SPC_OFS_BRAKE:  rd_mux = {28'h000_0000, brake_q};
      `SPC_OFS_WINDOW: rd_mux = {16'h0000, window_q};
      `SPC_OFS_VMAN:   rd_mux = {17'h0_0000, vman_q};
      `SPC_OFS_VMAX:   rd_mux = {17'h0_0000, vmax_q};
      `SPC_OFS_ESTOP:  rd_mux = {16'h0000, estop_q};
      `SPC_OFS_TRIG:   rd_mux = {17'h0_0000, trig_q};
      `SPC_OFS_SLOPE:  rd_mux = slope_q;
      `SPC_OFS_MINOUT: rd_mux = {17'h0_0000, minout_q};
      `SPC_OFS_EMERGENCY_OUTPUT_VALUE:   rd_mux = {16'h0000, emergency_output_value_q};
      `SPC_OFS_ISOL:   rd_mux = {4'h0, imax_q, 4'h0, imin_q};
      `SPC_OFS_STATUS: rd_mux = {20'h0_0000, err_q, pin_s[3:0], in_position, ready,
                                 valve_out_en, 1'b0};
      `SPC_OFS_POS:    rd_mux = {target_q, actual};
      `SPC_OFS_OUT:    rd_mux = {cmd_pos, out_q};
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data is sampled in the address phase so it stands for the whole data phase
  always @(posedge ref_clk) begin
    if (rst) begin
      wr_q    <= 1'b0;
      waddr_q <= 8'h00;
      hrdata  <= 32'h0000_0000;
    end else begin
      wr_q    <= acc & hwrite;
      waddr_q <= raddr;
      hrdata  <= (acc & ~hwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      ctrl_q   <= `SPC_RST_CTRL;
      gain_q   <= `SPC_RST_GAIN;
      brake_q  <= `SPC_RST_BRAKE;
      window_q <= `SPC_RST_WINDOW;
      vman_q   <= `SPC_RST_VMAN;
      vmax_q   <= `SPC_RST_VMAX;
      estop_q  <= `SPC_RST_ESTOP;
      trig_q   <= `SPC_RST_TRIG;
      slope_q  <= `SPC_RST_SLOPE;
      minout_q <= `SPC_RST_MINOUT;
      emergency_output_value_q   <= `SPC_RST_EMERGENCY_OUTPUT_VALUE;
      imin_q   <= `SPC_RST_IMIN;
      imax_q   <= `SPC_RST_IMAX;
    end else if (wr_q) begin
      case (waddr_q)
        `SPC_OFS_CTRL:   ctrl_q   <= hwdata[8:0];
        `SPC_OFS_GAIN:   gain_q   <= hwdata[15:0];
        `SPC_OFS_BRAKE:  brake_q  <= hwdata[3:0];
        `SPC_OFS_WINDOW: window_q <= hwdata[15:0];
        `SPC_OFS_VMAN:   vman_q   <= hwdata[14:0];
        `SPC_OFS_VMAX:   vmax_q   <= hwdata[14:0];
        `SPC_OFS_ESTOP:  estop_q  <= hwdata[15:0];
        `SPC_OFS_TRIG:   trig_q   <= hwdata[14:0];
        `SPC_OFS_SLOPE:  slope_q  <= hwdata;
        `SPC_OFS_MINOUT: minout_q <= hwdata[14:0];
        `SPC_OFS_EMERGENCY_OUTPUT_VALUE:   emergency_output_value_q   <= hwdata[15:0];
        `SPC_OFS_ISOL: begin
          imin_q <= hwdata[11:0];
          imax_q <= hwdata[27:16];
        end
        default: ;
      endcase
    end
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  reg  [5:0] pin_m1;
  reg  [5:0] pin_m2;
  reg  [5:0] pin_m3;
  wire [5:0] pin_raw = {sol_b_fault_pin, sol_a_fault_pin, jog_down_pin, jog_up_pin,
                        start_pin, enable_pin};

  // A rise is accepted only once the second and third stages agree; any disagreement between them clears the bit at once
  always @(posedge ref_clk) begin
    if (rst) begin
      pin_m1 <= 6'h00;
      pin_m2 <= 6'h00;
      pin_m3 <= 6'h00;
      pin_s  <= 6'h00;
    end else begin
      pin_m1 <= pin_raw;
      pin_m2 <= pin_m1;
      pin_m3 <= pin_m2;
      pin_s  <= (pin_s & ~(pin_m2 ^ pin_m3)) | (pin_m3 & ~(pin_m2 ^ pin_m3));
    end
  end

  wire en_s     = pin_s[0];
  wire start_s  = pin_s[1];
  wire jog_up   = pin_s[2];
  wire jog_dn   = pin_s[3];
  wire jog_one  = (jog_up ^ jog_dn) & ~start_s;

  // ****************************************
  // Input scaling and cable break
  // ****************************************
  wire        cur_in = ctrl_q[`SPC_CTRL_CUR_IN];

  function [15:0] spc_scale;
    input [15:0] code;
    input        cur;
    reg   [15:0] d;
    reg   [16:0] s;
    begin
      d = (code > `SPC_CODE_4MA) ? code - `SPC_CODE_4MA : 16'h0000;
      s = {1'b0, d} + {3'b000, d[15:2]};
      spc_scale = cur ? (s[16] ? 16'hFFFF : s[15:0]) : code;
    end
  endfunction

  assign actual  = spc_scale(feedback_code, cur_in);
  assign cmd_pos = spc_scale(cmd_pos_code, cur_in);
  wire [15:0] cmd_speed = spc_scale(cmd_speed_code, cur_in);

  // Break is only visible on live-zero inputs; a 0 V input cannot be told from a cut wire
  wire fb_break  = cur_in & (feedback_code < `SPC_CODE_BREAK);
  wire cmd_break = cur_in & (cmd_pos_code < `SPC_CODE_BREAK);
  wire pstage    = ctrl_q[`SPC_CTRL_PSTAGE];

  // ****************************************
  // Error latches
  // ****************************************
  reg  en_d1_q;
  wire en_rise = en_s & ~en_d1_q;
  wire [3:0] err_set = {pstage & en_s & pin_s[5], pstage & en_s & pin_s[4],
                        cmd_break, fb_break};
  wire sensor_err = err_q[0] | err_q[1];

  // A fault present in the clearing cycle stays latched
  always @(posedge ref_clk) begin
    if (rst) begin
      en_d1_q <= 1'b0;
      err_q   <= 4'h0;
    end else begin
      en_d1_q <= en_s;
      err_q   <= (en_rise ? 4'h0 : err_q) | err_set;
    end
  end

  // ****************************************
  // Sample period tick
  // ****************************************
  reg  [31:0] tick_cnt_q;
  wire        tick = (tick_cnt_q == SAMPLE_CYCLES - 1);

  always @(posedge ref_clk) begin
    if (rst)
      tick_cnt_q <= 32'h0000_0000;
    else
      tick_cnt_q <= tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
  end

  // ****************************************
  // Control law
  // ****************************************
  wire [16:0] err_s  = {1'b0, target_q} - {1'b0, actual};
  wire        e_neg  = err_s[16];
  wire [16:0] e_abs  = e_neg ? (17'h0_0000 - err_s) : err_s;
  wire [16:0] dist_b = 17'h0_0001 << brake_q;
  wire [1:0]  curve  = ctrl_q[`SPC_CTRL_CURVE_LO+1:`SPC_CTRL_CURVE_LO];
  wire [6:0]  boost  = (curve == `SPC_CURVE_ROOT3) ? 7'h20 :
                       (curve == `SPC_CURVE_ROOT5) ? 7'h40 : 7'h00;
  wire [16:0] remain = (e_abs < dist_b) ? dist_b - e_abs : 17'h0_0000;
  wire [23:0] bst_p  = boost * remain;
  wire [23:0] bst_x  = bst_p >> brake_q;
  // Gain in 1/16 steps: 16 far out, up to 16 times the curve factor at the target
  wire [7:0]  g_q    = 8'h10 + bst_x[7:0];
  wire [31:0] p1     = e_abs[15:0] * gain_q;
  wire [31:0] p2     = p1[31:8] * g_q;
  wire [27:0] m_ctl  = p2[31:4];
  wire [14:0] vlim   = ctrl_q[`SPC_CTRL_EXT_SPD] ? cmd_speed[15:1] : vmax_q;
  wire [14:0] m_req  = jog_one ? vman_q :
                       (m_ctl > {13'h0000, vlim} ? vlim : m_ctl[14:0]);
  wire [14:0] m_lim  = (m_req > vlim) ? vlim : m_req;
  wire        u_neg  = jog_one ? jog_dn : e_neg;

  // Two slopes split at the trigger point; the upper one starts from minout_q, not where the lower ends
  wire [30:0] seg1   = m_lim * slope_q[15:0];
  wire [14:0] over   = m_lim - trig_q;
  wire [30:0] seg2   = over * slope_q[31:16];
  wire [23:0] y_lo   = {1'b0, seg1[30:8]};
  wire [23:0] y_hi   = {9'h000, minout_q} + {1'b0, seg2[30:8]};
  wire [23:0] y_raw  = (m_lim < trig_q) ? y_lo : y_hi;
  wire [14:0] y_mag  = (y_raw > 24'h00_7FFF) ? 15'h7FFF : y_raw[14:0];
  wire [15:0] y_sgn  = u_neg ? (16'h0000 - {1'b0, y_mag}) : {1'b0, y_mag};
  wire        hold   = (jog_up & jog_dn & ~start_s) |
                       (~start_s & ~jog_one & (e_abs[15:0] <= window_q));

  // ****************************************
  // Target handling and filter state
  // ****************************************
  reg  [23:0] lag_q;
  reg         start_d_q;
  reg         jog_d_q;
  reg         en_d_q;
  wire [2:0]  lag_sh = ctrl_q[`SPC_CTRL_LAG_LO+2:`SPC_CTRL_LAG_LO];
  wire [23:0] lag_in = hold ? 24'h00_0000 : {y_sgn, 8'h00};
  wire [23:0] lag_df = lag_in - lag_q;
  wire [23:0] lag_st = $signed(lag_df) >>> lag_sh;
  wire [16:0] stop_up = {1'b0, actual} + {1'b0, estop_q};
  wire [16:0] stop_dn = {1'b0, actual} - {1'b0, estop_q};
  wire [15:0] stop_tg = (e_abs <= {1'b0, estop_q}) ? target_q :
                        e_neg ? (stop_dn[16] ? 16'h0000 : stop_dn[15:0]) :
                        (stop_up[16] ? 16'hFFFF : stop_up[15:0]);

  always @(posedge ref_clk) begin
    if (rst) begin
      target_q  <= 16'h0000;
      lag_q     <= 24'h00_0000;
      start_d_q <= 1'b0;
      jog_d_q   <= 1'b0;
      en_d_q    <= 1'b0;
    end else if (tick) begin
      start_d_q <= start_s;
      jog_d_q   <= jog_one;
      en_d_q    <= en_s;
      if (!en_s || !en_d_q) begin
        target_q <= actual;
        lag_q    <= 24'h00_0000;
      end else begin
        if (start_s)
          target_q <= cmd_pos;
        else if (start_d_q)
          target_q <= stop_tg;
        else if (jog_one || jog_d_q)
          target_q <= actual;
        lag_q <= lag_q + lag_st;
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  wire        emergency_output_value_on = ctrl_q[`SPC_CTRL_EMERGENCY_OUTPUT_VALUE_EN] & (sensor_err | ~en_s);
  wire        run     = en_s & ~sensor_err;
  wire [15:0] out_d   = emergency_output_value_on ? emergency_output_value_q : (run ? lag_q[23:8] : 16'h0000);
  wire [15:0] out_off = {~out_d[15], out_d[14:0]};
  wire [31:0] dac_p   = out_off * `SPC_SPAN_16MA;
  wire [15:0] dac_d   = `SPC_CODE_4MA + dac_p[31:16];
  wire [15:0] o_abs   = out_d[15] ? (16'h0000 - out_d) : out_d;
  wire [11:0] i_span  = (imax_q > imin_q) ? imax_q - imin_q : 12'h000;
  wire [27:0] i_p     = o_abs * i_span;
  wire [11:0] i_d     = imin_q + i_p[26:15];
  wire        drive   = (run | emergency_output_value_on) & ~pstage;
  wire        sdrive  = (run | emergency_output_value_on) & pstage & (o_abs != 16'h0000);

  always @(posedge ref_clk) begin
    if (rst) begin
      out_q          <= 16'h0000;
      ready          <= 1'b0;
      in_position    <= 1'b0;
      valve_out_en   <= 1'b0;
      valve_dac_code <= 16'h0000;
      monitor_code   <= 16'h0000;
      sol_a_ma       <= 12'h000;
      sol_b_ma       <= 12'h000;
    end else begin
      ready       <= run;
      in_position <= start_s & en_s & (e_abs[15:0] <= window_q) & ~e_abs[16];
      if (tick) begin
        out_q          <= out_d;
        valve_out_en   <= run | emergency_output_value_on;
        valve_dac_code <= drive ? dac_d : 16'h0000;
        monitor_code   <= dac_d;
        sol_a_ma       <= (sdrive & ~out_d[15]) ? i_d : 12'h000;
        sol_b_ma       <= (sdrive & out_d[15]) ? i_d : 12'h000;
      end
    end
  end

endmodule // spc_top

/* bench/spc_top_properties.sv */
`timescale 1ns/1ps
module spc_checker #(
  parameter SAMPLE_CYCLES = 50
) (
  input wire        ref_clk,        // Clock
  input wire        rst,            // Reset
  input wire        enable_pin,     // Enable pin
  input wire        start_pin,      // Start pin
  input wire        ready,          // Ready output
  input wire        in_position,    // In-position output
  input wire        valve_out_en,   // Valve stage active
  input wire [15:0] valve_dac_code, // Valve DAC code
  input wire [15:0] monitor_code,   // Monitor DAC code
  input wire [11:0] sol_a_ma,       // Solenoid A set point
  input wire [11:0] sol_b_ma        // Solenoid B set point
);
  // ****
  // Helper: cycles since enable pin went low
  // ****
  int unsigned off_cnt_q;
  always @(posedge ref_clk) begin
    if (rst || enable_pin) off_cnt_q <= 0;
    else if (off_cnt_q < 100000) off_cnt_q <= off_cnt_q + 1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_ready_needs_en: assert property (!enable_pin [*8] |-> !ready)
    else $error("ready high while enable low");
  chk_ready_rise_en: assert property ($rose(ready) |-> $past(enable_pin, 3))
    else $error("ready rose without enable");
  chk_inpos_start_off: assert property (!start_pin [*8] |-> !in_position)
    else $error("in position high while start off");
  chk_valve_idle_off: assert property (off_cnt_q > SAMPLE_CYCLES + 8 |-> !valve_out_en)
    else $error("valve stage active while disabled");
  chk_dac_idle_zero: assert property (!valve_out_en |-> valve_dac_code == 16'h0000)
    else $error("valve code nonzero while inactive");
  chk_dac_floor: assert property (valve_dac_code != 16'h0000 |-> valve_dac_code >= 16'h3333)
    else $error("valve code below 4 mA");
  chk_mon_floor: assert property ($changed(monitor_code) |-> monitor_code >= 16'h3333)
    else $error("monitor code below 4 mA");
  chk_out_per_tick: assert property ($changed(monitor_code) |=> $stable(monitor_code) [*8])
    else $error("monitor output changed between ticks");
  chk_sol_split: assert property (sol_a_ma != 12'h000 |-> sol_b_ma == 12'h000)
    else $error("both solenoids driven");
  chk_sol_a_range: assert property (sol_a_ma != 12'h000 |-> sol_a_ma inside {[12'h1F4:12'hA28]})
    else $error("solenoid A current out of range");
  chk_sol_b_range: assert property (sol_b_ma != 12'h000 |-> sol_b_ma inside {[12'h1F4:12'hA28]})
    else $error("solenoid B current out of range");
endmodule // spc_checker

/* bench/spc_plant.sv */
`timescale 1ns/1ps
module spc_plant (
  input  wire        ref_clk,      // Clock
  input  wire        freeze,       // Hold the rod still
  input  wire        load,         // Place the rod at load_pos
  input  wire [15:0] load_pos,     // Rod position to place
  input  wire [15:0] monitor_code, // Valve drive seen
  output wire [15:0] feedback_code // Sensor code
);
  // Rod speed follows the signed drive around mid scale; freeze lets the bench pin actual
  logic signed [31:0] acc_q = 32'h0000_0000;
  always @(posedge ref_clk) begin
    if (load) acc_q <= {6'h00, load_pos, 10'h000};
    else if (!freeze && monitor_code != 16'h0000)
      acc_q <= acc_q + ($signed({16'h0000, monitor_code}) - 32'sh0000_9999);
  end
  assign feedback_code = acc_q[25:10];
endmodule // spc_plant

/* bench/spc_top_tb_top.sv */
`timescale 1ns/1ps
module spc_top_tb_top;
  localparam int SMP = 50;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic        enable_pin = 1'b0;
  logic        start_pin = 1'b0;
  logic        jog_up_pin = 1'b0;
  logic        jog_down_pin = 1'b0;
  logic        sol_a_fault_pin = 1'b0;
  logic        sol_b_fault_pin = 1'b0;
  logic [15:0] cmd_pos_code = 16'h0000;
  logic [15:0] cmd_speed_code = 16'h0000;
  logic        freeze = 1'b1;
  logic        load = 1'b1;
  logic [15:0] load_pos = 16'h8000;
  logic [15:0] lfsr_q = 16'h000B;
  logic [15:0] fb;
  logic        rd_ph = 1'b0;
  logic [31:0] exp_q[$];
  int          num_errors = 0;
  int          samples_checked = 0;
  wire         hready, hreadyout, hresp, ready, in_position, valve_out_en;
  wire  [31:0] hrdata;
  wire  [15:0] feedback_code, valve_dac_code, monitor_code;
  wire  [11:0] sol_a_ma, sol_b_ma;
  assign hready = hreadyout;
  always #5 ref_clk = ~ref_clk;
  spc_top #(.SAMPLE_CYCLES(SMP)) u_dut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .enable_pin(enable_pin), .start_pin(start_pin), .jog_up_pin(jog_up_pin),
    .jog_down_pin(jog_down_pin), .sol_a_fault_pin(sol_a_fault_pin),
    .sol_b_fault_pin(sol_b_fault_pin),
    .cmd_pos_code(cmd_pos_code), .feedback_code(feedback_code),
    .cmd_speed_code(cmd_speed_code), .ready(ready), .in_position(in_position),
    .valve_out_en(valve_out_en), .valve_dac_code(valve_dac_code),
    .monitor_code(monitor_code), .sol_a_ma(sol_a_ma), .sol_b_ma(sol_b_ma));
  spc_plant u_plant (.ref_clk(ref_clk), .freeze(freeze), .load(load), .load_pos(load_pos),
    .monitor_code(monitor_code), .feedback_code(feedback_code));
  // ****
  // Shared tasks
  // ****
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      input logic [31:0] exp);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= wr; hsize <= 3'h2;
    @(posedge ref_clk);
    while (hready !== 1'b1) @(posedge ref_clk);
    htrans <= 2'h0; hsel <= 1'b0; hwdata <= d;
    if (!wr) exp_q.push_back(exp);
    @(posedge ref_clk);
    while (hready !== 1'b1) @(posedge ref_clk);
  endtask
  task automatic ticks(input int n);
    repeat (n * SMP) @(posedge ref_clk);
  endtask
  task automatic wait_ready;
    for (int i = 0; i < 20 && ready !== 1'b1; i++) @(posedge ref_clk);
  endtask
  task automatic place_rod(input logic [15:0] p);
    load_pos <= p; load <= 1'b1;
    @(posedge ref_clk);
    load <= 1'b0;
  endtask
  // Read data is judged at the edge closing its data phase
  always @(posedge ref_clk) begin
    if (rd_ph && exp_q.size() > 0) check("hrdata", hrdata, exp_q.pop_front());
    rd_ph <= hsel && htrans[1] && !hwrite && hready;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    $display("mismatch watchdog expected done seen hang");
    end_sim();
  end
  // ****
  // Main sequence
  // ****
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0; load <= 1'b0;
    @(posedge ref_clk);
    xfer(1'b0, 32'h0000_0000, 32'h0, 32'h0000_0044);
    xfer(1'b0, 32'h0000_002C, 32'h0, 32'h0A28_01F4);
    xfer(1'b0, 32'h0000_003C, 32'h0, 32'h0000_0000);
    lfsr_q = lfsr_next(lfsr_q);
    xfer(1'b1, 32'h0000_0004, {16'h0000, 8'h01, lfsr_q[7:0]}, 32'h0);
    xfer(1'b0, 32'h0000_0004, 32'h0, {16'h0000, 8'h01, lfsr_q[7:0]});
    $display("test regs done");
    lfsr_q = lfsr_next(lfsr_q);
    fb = 16'h4000 + {2'b00, lfsr_q[13:0]};
    cmd_pos_code <= fb; cmd_speed_code <= lfsr_q;
    place_rod(fb);
    ticks(2);
    check("ready_off", ready, 1'b0);
    check("valve_off", valve_out_en, 1'b0);
    enable_pin <= 1'b1;
    wait_ready();
    check("ready_on", ready, 1'b1);
    ticks(2);
    check("valve_on", valve_out_en, 1'b1);
    check("dac_mid", valve_dac_code, 16'h9999);
    check("inpos_idle", in_position, 1'b0);
    $display("test enable done");
    jog_up_pin <= 1'b1; jog_down_pin <= 1'b1;
    ticks(4);
    check("both_jogs", monitor_code, 16'h9999);
    jog_down_pin <= 1'b0; freeze <= 1'b0;
    ticks(4);
    check("jog_drive", monitor_code > 16'h9999, 1'b1);
    check("jog_moved", feedback_code > fb, 1'b1);
    freeze <= 1'b1;
    @(posedge ref_clk);
    jog_up_pin <= 1'b0;
    ticks(40);
    check("jog_hold", monitor_code, 16'h9999);
    xfer(1'b0, 32'h0000_0034, 32'h0, {feedback_code, feedback_code});
    $display("test jog done");
    fb = feedback_code;
    cmd_pos_code <= fb;
    start_pin <= 1'b1;
    ticks(1);
    check("inpos_on", in_position, 1'b1);
    cmd_pos_code <= fb + 16'h0800;
    ticks(4);
    check("inpos_off", in_position, 1'b0);
    check("start_drive", monitor_code > 16'h9999, 1'b1);
    start_pin <= 1'b0;
    ticks(2);
    check("inpos_stop", in_position, 1'b0);
    xfer(1'b0, 32'h0000_0034, 32'h0, {fb + 16'h0400, fb});
    $display("test start done");
    xfer(1'b1, 32'h0000_0000, 32'h0000_0045, 32'h0);
    place_rod(16'h1000);
    ticks(1);
    check("ready_break", ready, 1'b0);
    place_rod(fb);
    ticks(1);
    check("ready_latched", ready, 1'b0);
    enable_pin <= 1'b0;
    ticks(2);
    check("valve_dis", valve_out_en, 1'b0);
    check("dac_dis", valve_dac_code, 16'h0000);
    enable_pin <= 1'b1;
    wait_ready();
    check("ready_clear", ready, 1'b1);
    $display("test fault done");
    xfer(1'b1, 32'h0000_0000, 32'h0000_0144, 32'h0);
    jog_up_pin <= 1'b1;
    ticks(8);
    check("sol_a", sol_a_ma inside {[12'h1F4:12'hA28]} && sol_b_ma == 12'h000, 1'b1);
    check("dac_ps", valve_dac_code, 16'h0000);
    jog_up_pin <= 1'b0; jog_down_pin <= 1'b1;
    ticks(8);
    check("sol_b", sol_b_ma inside {[12'h1F4:12'hA28]} && sol_a_ma == 12'h000, 1'b1);
    // Solenoid fault latches in status but must not drop ready
    sol_a_fault_pin <= 1'b1;
    ticks(1);
    xfer(1'b0, 32'h0000_0030, 32'h0, 32'h0000_0496);
    check("ready_solfault", ready, 1'b1);
    $display("test power done");
    end_sim();
  end
endmodule // spc_top_tb_top
bind spc_top spc_checker #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_chk (.ref_clk(ref_clk), .rst(rst),
  .enable_pin(enable_pin), .start_pin(start_pin), .ready(ready), .in_position(in_position),
  .valve_out_en(valve_out_en), .valve_dac_code(valve_dac_code), .monitor_code(monitor_code),
  .sol_a_ma(sol_a_ma), .sol_b_ma(sol_b_ma));
